// ---- prog_sel_pkg.sv ----
// Shared constants and types for the programming-mode entry block
package prog_sel_pkg;

  localparam int CLK_HZ         = 25_000_000;
  localparam int SYNC_STAGES    = 2;
  localparam int SETTLE_CYCLES  = SYNC_STAGES + 1;

  // Quiet time on the voltage pin that ends the pulse sequence
  localparam int SELECT_QUIET_US     = 1000;
  localparam int SELECT_QUIET_CYCLES = (CLK_HZ / 1_000_000) * SELECT_QUIET_US;

  // Pulse counts that pick a channel; the counter stops at PULSES_OVER
  localparam logic [3:0] PULSES_CLOCKED      = 4'h0;
  localparam logic [3:0] PULSES_CLOCKED_HS   = 4'h3;
  localparam logic [3:0] PULSES_PRIMARY      = 4'h8;
  localparam logic [3:0] PULSES_SECONDARY    = 4'h9;
  localparam logic [3:0] PULSES_PRIMARY_HS   = 4'hB;
  localparam logic [3:0] PULSES_MAX          = 4'hB;
  localparam logic [3:0] PULSES_OVER         = 4'hC;

  // Asynchronous bit rates
  localparam int SLOWEST_BPS           = 4800;
  localparam int SECONDARY_FASTEST_BPS = 76800;
  localparam int PRIMARY_FASTEST_BPS   = 38400;
  localparam int LONGEST_BIT_CYCLES    = CLK_HZ / SLOWEST_BPS;
  localparam int SECONDARY_SHORT_BIT_CYCLES =
    (CLK_HZ + SECONDARY_FASTEST_BPS - 1) / SECONDARY_FASTEST_BPS;
  localparam int PRIMARY_SHORT_BIT_CYCLES =
    (CLK_HZ + PRIMARY_FASTEST_BPS - 1) / PRIMARY_FASTEST_BPS;

  // First command is all zeros: start bit plus eight data bits sit low
  localparam int RESET_CMD_LOW_BITS = 9;
  localparam int PERIOD_W           = 16;
  localparam int BYTE_BITS          = 8;

  // Pin slots in the output mux
  localparam int PIN_CLK_OUT  = 0;
  localparam int PIN_PRI_TX   = 1;
  localparam int PIN_SEC_TX   = 2;
  localparam int PIN_HS       = 3;
  localparam int PIN_COUNT    = 4;

  typedef enum logic [2:0] {
    ST_SETTLE, ST_NORMAL, ST_COUNT, ST_ACTIVE, ST_LOCKED
  } mode_state_t;

  typedef enum logic [2:0] {
    CH_NONE, CH_CLOCKED, CH_CLOCKED_HS, CH_PRIMARY, CH_SECONDARY, CH_PRIMARY_HS
  } channel_t;

  typedef enum logic [2:0] {
    MS_IDLE, MS_WAIT_HIGH, MS_WAIT_LOW, MS_COUNT, MS_DONE
  } measure_state_t;

endpackage

// ---- level_sync.sv ----
// Two-stage synchroniser for levels entering a clock domain
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1
) (
  // Clock and control
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             en_i,
  // Data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else if (en_i) begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end

endmodule // level_sync
`default_nettype wire

// ---- bit_time_measure.sv ----
// Measures the receive bit period from the low run of the first command
`timescale 1ns/1ps
`default_nettype none
module bit_time_measure #(
  parameter int PERIOD_W = prog_sel_pkg::PERIOD_W,
  parameter int LOW_BITS = prog_sel_pkg::RESET_CMD_LOW_BITS
) (
  // Clock and control
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                ce_i,
  input  wire logic                arm_i,
  // Synchronised receive line
  input  wire logic                rx_i,
  // Result
  output logic      [PERIOD_W-1:0] period_o,
  output logic                     valid_o
);

  prog_sel_pkg::measure_state_t state_reg;
  logic [PERIOD_W-1:0]          run_reg;
  logic [PERIOD_W-1:0]          period_calc;
  logic                         run_full;

  // Divide once, at the end; a constant divisor keeps it cheap
  assign period_calc = PERIOD_W'(run_reg / PERIOD_W'(LOW_BITS));
  assign run_full    = &run_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= prog_sel_pkg::MS_IDLE;
      run_reg   <= '0;
      period_o  <= '0;
      valid_o   <= 1'b0;
    end else if (ce_i) begin
      unique case (state_reg)
        prog_sel_pkg::MS_IDLE: if (arm_i) begin
          state_reg <= prog_sel_pkg::MS_WAIT_HIGH;
        end
        // Line must idle high before a start edge counts
        prog_sel_pkg::MS_WAIT_HIGH: if (rx_i) begin
          state_reg <= prog_sel_pkg::MS_WAIT_LOW;
        end
        prog_sel_pkg::MS_WAIT_LOW: if (!rx_i) begin
          run_reg   <= PERIOD_W'(1);
          state_reg <= prog_sel_pkg::MS_COUNT;
        end
        prog_sel_pkg::MS_COUNT: if (rx_i || run_full) begin
          period_o  <= period_calc;
          valid_o   <= 1'b1;
          state_reg <= prog_sel_pkg::MS_DONE;
        end else begin
          run_reg <= run_reg + PERIOD_W'(1);
        end
        prog_sel_pkg::MS_DONE: state_reg <= prog_sel_pkg::MS_DONE;
      endcase
    end
  end

endmodule // bit_time_measure
`default_nettype wire

// ---- prog_mode_select.sv ----
// Flash programming mode entry, channel selection and pin steering
`timescale 1ns/1ps
`default_nettype none
module prog_mode_select #(
  parameter int SELECT_QUIET_CYCLES = prog_sel_pkg::SELECT_QUIET_CYCLES
) (
  // Core clock, reset, enable
  input  wire logic                            clk_i,
  input  wire logic                            rst_n_i,
  input  wire logic                            ce_i,
  // Link clock from the programmer
  input  wire logic                            clocked_serial_clock_i,
  // Programming voltage at write level
  input  wire logic                            prog_voltage_i,
  // Receive pins
  input  wire logic                            clocked_serial_in_i,
  input  wire logic                            primary_async_receive_i,
  input  wire logic                            secondary_async_receive_i,
  // Transmit data from the command engine
  input  wire logic                            tx_serial_bit_i,
  input  wire logic                            tx_async_bit_i,
  input  wire logic                            handshake_busy_i,
  // Transmit pins
  output logic                                 clocked_serial_out_o,
  output logic                                 clocked_serial_out_oe_n_o,
  output logic                                 primary_async_transmit_o,
  output logic                                 primary_async_transmit_oe_n_o,
  output logic                                 secondary_async_transmit_o,
  output logic                                 secondary_async_transmit_oe_n_o,
  output logic                                 handshake_line_o,
  output logic                                 handshake_line_oe_n_o,
  // Mode status
  output logic                                 prog_mode_o,
  output logic                                 normal_mode_o,
  output prog_sel_pkg::channel_t               channel_o,
  output logic                                 select_error_o,
  // Received data toward the command engine
  output logic                                 rx_bit_o,
  output logic [prog_sel_pkg::BYTE_BITS-1:0]   rx_byte_o,
  output logic                                 rx_byte_valid_o,
  // Asynchronous bit timing
  output logic [prog_sel_pkg::PERIOD_W-1:0]    bit_period_o,
  output logic                                 bit_period_valid_o,
  output logic                                 bit_rate_err_o
);

  localparam int QW = $clog2(SELECT_QUIET_CYCLES + 1);
  localparam int BW = prog_sel_pkg::BYTE_BITS;
  localparam int PW = prog_sel_pkg::PERIOD_W;
  localparam int NP = prog_sel_pkg::PIN_COUNT;

  prog_sel_pkg::mode_state_t state_reg;
  prog_sel_pkg::channel_t    chan_reg;
  prog_sel_pkg::channel_t    chan_dec;
  logic [1:0]                settle_reg;
  logic [3:0]                pulse_cnt_reg;
  logic [QW-1:0]             quiet_cnt_reg;
  logic                      pv_prev_reg;

  // Pin synchronisers: voltage pin and the three receive lines
  logic [3:0] pins_sync;
  logic       pv_s;
  logic       clk_rx_s;
  logic       pri_rx_s;
  logic       sec_rx_s;

  level_sync #(.WIDTH(4)) u_pin_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .en_i    (ce_i),
    .d_i     ({prog_voltage_i, clocked_serial_in_i,
               primary_async_receive_i, secondary_async_receive_i}),
    .q_o     (pins_sync)
  );

  assign pv_s     = pins_sync[3];
  assign clk_rx_s = pins_sync[2];
  assign pri_rx_s = pins_sync[1];
  assign sec_rx_s = pins_sync[0];

  // Pulse sequence decode
  logic pv_rise;
  logic quiet_done;
  logic settled;
  logic is_clocked;
  logic is_primary;
  logic is_async;
  logic uses_hs;
  logic active;

  assign pv_rise    = pv_s && !pv_prev_reg;
  assign quiet_done = (quiet_cnt_reg == QW'(SELECT_QUIET_CYCLES));
  assign settled    = (settle_reg == 2'(prog_sel_pkg::SETTLE_CYCLES - 1));

  always_comb begin
    unique case (pulse_cnt_reg)
      prog_sel_pkg::PULSES_CLOCKED:    chan_dec = prog_sel_pkg::CH_CLOCKED;
      prog_sel_pkg::PULSES_CLOCKED_HS: chan_dec = prog_sel_pkg::CH_CLOCKED_HS;
      prog_sel_pkg::PULSES_PRIMARY:    chan_dec = prog_sel_pkg::CH_PRIMARY;
      prog_sel_pkg::PULSES_SECONDARY:  chan_dec = prog_sel_pkg::CH_SECONDARY;
      prog_sel_pkg::PULSES_PRIMARY_HS: chan_dec = prog_sel_pkg::CH_PRIMARY_HS;
      default:                         chan_dec = prog_sel_pkg::CH_NONE;
    endcase
  end

  assign active     = (state_reg == prog_sel_pkg::ST_ACTIVE);
  assign is_clocked = (chan_reg == prog_sel_pkg::CH_CLOCKED) ||
                      (chan_reg == prog_sel_pkg::CH_CLOCKED_HS);
  assign is_primary = (chan_reg == prog_sel_pkg::CH_PRIMARY) ||
                      (chan_reg == prog_sel_pkg::CH_PRIMARY_HS);
  assign is_async   = is_primary || (chan_reg == prog_sel_pkg::CH_SECONDARY);
  assign uses_hs    = (chan_reg == prog_sel_pkg::CH_CLOCKED_HS) ||
                      (chan_reg == prog_sel_pkg::CH_PRIMARY_HS);

  // Mode state machine; only a fresh reset leaves programming mode
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg     <= prog_sel_pkg::ST_SETTLE;
      chan_reg      <= prog_sel_pkg::CH_NONE;
      settle_reg    <= '0;
      pulse_cnt_reg <= prog_sel_pkg::PULSES_CLOCKED;
      quiet_cnt_reg <= '0;
      pv_prev_reg   <= 1'b0;
    end else if (ce_i) begin
      pv_prev_reg <= pv_s;
      unique case (state_reg)
        // Wait for the synchroniser to fill before trusting the strap
        prog_sel_pkg::ST_SETTLE: if (settled) begin
          state_reg <= pv_s ? prog_sel_pkg::ST_COUNT : prog_sel_pkg::ST_NORMAL;
        end else begin
          settle_reg <= settle_reg + 2'(1);
        end
        prog_sel_pkg::ST_COUNT: begin
          if (pv_rise && pulse_cnt_reg != prog_sel_pkg::PULSES_OVER) begin
            pulse_cnt_reg <= pulse_cnt_reg + 4'(1);
          end
          if (!pv_s || pv_rise) begin
            quiet_cnt_reg <= '0;
          end else if (quiet_done) begin
            chan_reg  <= chan_dec;
            state_reg <= (chan_dec == prog_sel_pkg::CH_NONE) ?
                         prog_sel_pkg::ST_LOCKED : prog_sel_pkg::ST_ACTIVE;
          end else begin
            quiet_cnt_reg <= quiet_cnt_reg + QW'(1);
          end
        end
        prog_sel_pkg::ST_NORMAL: state_reg <= prog_sel_pkg::ST_NORMAL;
        prog_sel_pkg::ST_ACTIVE: state_reg <= prog_sel_pkg::ST_ACTIVE;
        prog_sel_pkg::ST_LOCKED: state_reg <= prog_sel_pkg::ST_LOCKED;
        default:                 state_reg <= prog_sel_pkg::ST_SETTLE;
      endcase
    end
  end

  // Pin steering: a pin not owned by the channel stays an input, as after reset
  logic [NP-1:0] pin_used;
  logic [NP-1:0] pin_data;
  logic [NP-1:0] pin_out_reg;
  logic [NP-1:0] pin_oe_n_reg;

  assign pin_used[prog_sel_pkg::PIN_CLK_OUT] = active && is_clocked;
  assign pin_used[prog_sel_pkg::PIN_PRI_TX]  = active && is_primary;
  assign pin_used[prog_sel_pkg::PIN_SEC_TX]  =
    active && (chan_reg == prog_sel_pkg::CH_SECONDARY);
  assign pin_used[prog_sel_pkg::PIN_HS]      = active && uses_hs;
  assign pin_data[prog_sel_pkg::PIN_CLK_OUT] = tx_serial_bit_i;
  assign pin_data[prog_sel_pkg::PIN_PRI_TX]  = tx_async_bit_i;
  assign pin_data[prog_sel_pkg::PIN_SEC_TX]  = tx_async_bit_i;
  assign pin_data[prog_sel_pkg::PIN_HS]      = handshake_busy_i;

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_pin
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          pin_out_reg[gi]  <= 1'b0;
          pin_oe_n_reg[gi] <= 1'b1;
        end else if (ce_i) begin
          pin_out_reg[gi]  <= pin_used[gi] & pin_data[gi];
          pin_oe_n_reg[gi] <= ~pin_used[gi];
        end
      end
    end
  endgenerate

  assign clocked_serial_out_o            = pin_out_reg[prog_sel_pkg::PIN_CLK_OUT];
  assign clocked_serial_out_oe_n_o       = pin_oe_n_reg[prog_sel_pkg::PIN_CLK_OUT];
  assign primary_async_transmit_o        = pin_out_reg[prog_sel_pkg::PIN_PRI_TX];
  assign primary_async_transmit_oe_n_o   = pin_oe_n_reg[prog_sel_pkg::PIN_PRI_TX];
  assign secondary_async_transmit_o      = pin_out_reg[prog_sel_pkg::PIN_SEC_TX];
  assign secondary_async_transmit_oe_n_o = pin_oe_n_reg[prog_sel_pkg::PIN_SEC_TX];
  assign handshake_line_o                = pin_out_reg[prog_sel_pkg::PIN_HS];
  assign handshake_line_oe_n_o           = pin_oe_n_reg[prog_sel_pkg::PIN_HS];

  // Link side: shifts the clocked serial input on the programmer's clock
  logic          link_en_core;
  logic          link_en_s;
  logic [BW-1:0] link_shift_reg;
  logic [BW-1:0] link_byte_reg;
  logic [2:0]    link_bits_reg;
  logic          link_tgl_reg;
  logic          link_last;

  assign link_en_core = active && is_clocked;
  assign link_last    = (link_bits_reg == 3'(BW - 1));

  // Link clock only runs in frames, so its reset is the synchronised enable
  level_sync #(.WIDTH(1)) u_link_en_sync (
    .clk_i   (clocked_serial_clock_i),
    .rst_n_i (1'b1),
    .en_i    (1'b1),
    .d_i     (link_en_core),
    .q_o     (link_en_s)
  );

  always_ff @(posedge clocked_serial_clock_i) begin
    if (!link_en_s) begin
      link_shift_reg <= '0;
      link_byte_reg  <= '0;
      link_bits_reg  <= '0;
      link_tgl_reg   <= 1'b0;
    end else begin
      link_shift_reg <= {link_shift_reg[BW-2:0], clocked_serial_in_i};
      link_bits_reg  <= link_bits_reg + 3'(1);
      if (link_last) begin
        link_byte_reg <= {link_shift_reg[BW-2:0], clocked_serial_in_i};
        link_tgl_reg  <= ~link_tgl_reg;
      end
    end
  end

  // Byte crossing: the toggle is synchronised; the held byte is stable for
  // eight link clocks, far longer than the three core cycles it needs
  logic tgl_s;
  logic tgl_prev_reg;
  logic byte_event;

  level_sync #(.WIDTH(1)) u_tgl_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .en_i    (ce_i),
    .d_i     (link_tgl_reg),
    .q_o     (tgl_s)
  );

  assign byte_event = (tgl_s != tgl_prev_reg) && link_en_core;

  // Asynchronous bit-period measurement on the chosen receive line
  logic          async_rx_s;
  logic          meas_arm;
  logic [PW-1:0] period_w;
  logic          period_valid_w;
  logic          period_low;
  logic          period_high;

  assign async_rx_s = is_primary ? pri_rx_s : sec_rx_s;
  assign meas_arm   = active && is_async;

  bit_time_measure #(
    .PERIOD_W (PW),
    .LOW_BITS (prog_sel_pkg::RESET_CMD_LOW_BITS)
  ) u_measure (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .ce_i     (ce_i),
    .arm_i    (meas_arm),
    .rx_i     (async_rx_s),
    .period_o (period_w),
    .valid_o  (period_valid_w)
  );

  assign period_high = (period_w > PW'(prog_sel_pkg::LONGEST_BIT_CYCLES));
  assign period_low  = is_primary ?
    (period_w < PW'(prog_sel_pkg::PRIMARY_SHORT_BIT_CYCLES)) :
    (period_w < PW'(prog_sel_pkg::SECONDARY_SHORT_BIT_CYCLES));

  // Registered status and receive outputs
  logic rx_bit_next;

  assign rx_bit_next = !active   ? 1'b1 :
                       is_clocked ? clk_rx_s : async_rx_s;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tgl_prev_reg       <= 1'b0;
      prog_mode_o        <= 1'b0;
      normal_mode_o      <= 1'b0;
      channel_o          <= prog_sel_pkg::CH_NONE;
      select_error_o     <= 1'b0;
      rx_bit_o           <= 1'b1;
      rx_byte_o          <= '0;
      rx_byte_valid_o    <= 1'b0;
      bit_period_o       <= '0;
      bit_period_valid_o <= 1'b0;
      bit_rate_err_o     <= 1'b0;
    end else if (ce_i) begin
      tgl_prev_reg       <= tgl_s;
      prog_mode_o        <= (state_reg == prog_sel_pkg::ST_COUNT) || active ||
                            (state_reg == prog_sel_pkg::ST_LOCKED);
      normal_mode_o      <= (state_reg == prog_sel_pkg::ST_NORMAL);
      channel_o          <= chan_reg;
      select_error_o     <= (state_reg == prog_sel_pkg::ST_LOCKED);
      rx_bit_o           <= rx_bit_next;
      rx_byte_valid_o    <= byte_event;
      if (byte_event) begin
        rx_byte_o <= link_byte_reg;
      end
      bit_period_o       <= period_w;
      bit_period_valid_o <= period_valid_w;
      bit_rate_err_o     <= period_valid_w && (period_low || period_high);
    end
  end

endmodule // prog_mode_select
`default_nettype wire

// ---- prog_sel_assertions.sv ----
// Concurrent checks on the programming-mode entry block
`timescale 1ns/1ps
`default_nettype none
module prog_sel_assertions #(
  parameter int PW = prog_sel_pkg::PERIOD_W
) (
  // Clock, reset, engine levels
  input wire logic                   clk_i,
  input wire logic                   rst_n_i,
  input wire logic                   tx_async_bit_i,
  input wire logic                   handshake_busy_i,
  // Pins
  input wire logic                   clocked_serial_out_o,
  input wire logic                   clocked_serial_out_oe_n_o,
  input wire logic                   primary_async_transmit_o,
  input wire logic                   primary_async_transmit_oe_n_o,
  input wire logic                   secondary_async_transmit_o,
  input wire logic                   secondary_async_transmit_oe_n_o,
  input wire logic                   handshake_line_o,
  input wire logic                   handshake_line_oe_n_o,
  // Status
  input wire logic                   prog_mode_o,
  input wire logic                   normal_mode_o,
  input wire prog_sel_pkg::channel_t channel_o,
  input wire logic                   select_error_o,
  input wire logic                   rx_bit_o,
  input wire logic                   rx_byte_valid_o,
  input wire logic [PW-1:0]          bit_period_o,
  input wire logic                   bit_period_valid_o,
  input wire logic                   bit_rate_err_o
);
  wire       chan_none = channel_o == prog_sel_pkg::CH_NONE;
  wire       chan_slow = channel_o inside {prog_sel_pkg::CH_PRIMARY, prog_sel_pkg::CH_PRIMARY_HS};
  wire       chan_csi  = channel_o inside {prog_sel_pkg::CH_CLOCKED, prog_sel_pkg::CH_CLOCKED_HS};
  wire [3:0] oe_n_all  = {clocked_serial_out_oe_n_o, primary_async_transmit_oe_n_o,
                          secondary_async_transmit_oe_n_o, handshake_line_oe_n_o};
  wire [3:0] out_all   = {clocked_serial_out_o, primary_async_transmit_o,
                          secondary_async_transmit_o, handshake_line_o};

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_unused_pins_idle: assert property (chan_none && $past(chan_none) |->
    oe_n_all == 4'hF && out_all == 4'h0) else $error("pin driven with no channel");
  a_clocked_pins_only: assert property (
    channel_o == prog_sel_pkg::CH_CLOCKED && $past(channel_o) == prog_sel_pkg::CH_CLOCKED
    |-> oe_n_all == 4'h7) else $error("clocked mode drives wrong pins");
  a_handshake_follows: assert property (
    channel_o == prog_sel_pkg::CH_CLOCKED_HS && $past(channel_o) == prog_sel_pkg::CH_CLOCKED_HS
    |-> !handshake_line_oe_n_o && handshake_line_o == $past(handshake_busy_i))
    else $error("handshake line not driven from busy");
  a_primary_follows: assert property (
    channel_o == prog_sel_pkg::CH_PRIMARY && $past(channel_o) == prog_sel_pkg::CH_PRIMARY
    |-> oe_n_all == 4'hB && primary_async_transmit_o == $past(tx_async_bit_i))
    else $error("primary transmit pin wrong");
  a_modes_exclusive: assert property (!(prog_mode_o && normal_mode_o) &&
    (chan_none || prog_mode_o)) else $error("mode flags inconsistent");
  a_channel_held: assert property (!chan_none |=> $stable(channel_o))
    else $error("channel changed before reset");
  a_bad_count_idle: assert property (select_error_o |-> chan_none && rx_bit_o &&
    !rx_byte_valid_o && !bit_period_valid_o) else $error("traffic after bad count");
  a_byte_single_pulse: assert property (rx_byte_valid_o |-> chan_csi ##1 !rx_byte_valid_o)
    else $error("byte strobe wrong");
  a_period_sticky: assert property (bit_period_valid_o |=>
    bit_period_valid_o && $stable(bit_period_o)) else $error("bit timing not held");
  a_rate_window: assert property ($rose(bit_period_valid_o) |-> !chan_none && !chan_csi &&
    bit_rate_err_o == (bit_period_o > prog_sel_pkg::LONGEST_BIT_CYCLES || bit_period_o <
    (chan_slow ? prog_sel_pkg::PRIMARY_SHORT_BIT_CYCLES : prog_sel_pkg::SECONDARY_SHORT_BIT_CYCLES)))
    else $error("rate flag wrong");
endmodule // prog_sel_assertions

bind prog_mode_select prog_sel_assertions u_chk (.*);
`default_nettype wire

// ---- prog_programmer_model.sv ----
// Behavioural flash programmer at the target's pins
`timescale 1ns/1ps
`default_nettype none
module prog_programmer_model (
  // Core clock seen at the target
  input  wire logic clk_i,
  // Programmer outputs
  output logic      rst_n_o,
  output logic      prog_voltage_o,
  output logic      link_clk_o,
  output logic      serial_data_o,
  output logic      primary_rx_o,
  output logic      secondary_rx_o
);
  initial begin
    rst_n_o = 1'b0;
    prog_voltage_o = 1'b0;
    link_clk_o = 1'b0;
    serial_data_o = 1'b0;
    primary_rx_o = 1'b1;
    secondary_rx_o = 1'b1;
  end
  // Sole driver of target reset
  task automatic enter(input logic vpp);
    @(posedge clk_i);
    rst_n_o <= 1'b0;
    prog_voltage_o <= vpp;
    repeat (3) @(posedge clk_i);
    rst_n_o <= 1'b1;
  endtask
  // Each phase outlasts the synchroniser
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_i);
      prog_voltage_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      prog_voltage_o <= 1'b1;
      repeat (3) @(posedge clk_i);
    end
  endtask
  // Link clock stands still between frames
  task automatic clock_edges(input int n);
    repeat (n) begin
      #40 link_clk_o = 1'b1;
      #40 link_clk_o = 1'b0;
    end
  endtask
  // MSB first; line shows the inverse of the last bit once released
  task automatic send_byte(input logic [7:0] b);
    #7;
    for (int i = 7; i >= 0; i--) begin
      serial_data_o = b[i];
      clock_edges(1);
    end
    serial_data_o = ~b[0];
  endtask
  // Zero-byte reset command: nine bit times low
  task automatic send_reset_cmd(input logic secondary, input int bit_cycles);
    @(posedge clk_i);
    if (secondary) secondary_rx_o <= 1'b0;
    else primary_rx_o <= 1'b0;
    repeat (9 * bit_cycles) @(posedge clk_i);
    primary_rx_o <= 1'b1;
    secondary_rx_o <= 1'b1;
  endtask
endmodule // prog_programmer_model
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the programming-mode entry block
`timescale 1ns/1ps
`default_nettype none
`define EXPECT_EQ(got, exp, msg) begin n_compared++; if ((got) !== (exp)) begin \
  error_cnt++; $display("BAD %0t %s", $time, msg); end end
module tb_top;
  localparam int QUIET = 20;
  localparam int LIMIT = 40000;
  logic clk_i, ce_i, tx_serial_bit_i, tx_async_bit_i, handshake_busy_i;
  wire  rst_n_i, vpp, sclk, sdin, prx, srx;
  logic cso, cso_oe_n, pto, pto_oe_n, sto, sto_oe_n, hso, hso_oe_n;
  logic prog_mode, normal_mode, sel_err, rx_bit, byte_valid, per_valid, rate_err;
  logic [prog_sel_pkg::BYTE_BITS-1:0] rx_byte;
  logic [prog_sel_pkg::PERIOD_W-1:0]  period;
  prog_sel_pkg::channel_t             channel;
  int                                 error_cnt, n_compared, cyc;
  logic [7:0]                         bytes_q[$];

  prog_mode_select #(.SELECT_QUIET_CYCLES(QUIET)) u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .clocked_serial_clock_i(sclk),
    .prog_voltage_i(vpp), .clocked_serial_in_i(sdin), .primary_async_receive_i(prx),
    .secondary_async_receive_i(srx), .tx_serial_bit_i(tx_serial_bit_i),
    .tx_async_bit_i(tx_async_bit_i), .handshake_busy_i(handshake_busy_i),
    .clocked_serial_out_o(cso), .clocked_serial_out_oe_n_o(cso_oe_n),
    .primary_async_transmit_o(pto), .primary_async_transmit_oe_n_o(pto_oe_n),
    .secondary_async_transmit_o(sto), .secondary_async_transmit_oe_n_o(sto_oe_n),
    .handshake_line_o(hso), .handshake_line_oe_n_o(hso_oe_n), .prog_mode_o(prog_mode),
    .normal_mode_o(normal_mode), .channel_o(channel), .select_error_o(sel_err),
    .rx_bit_o(rx_bit), .rx_byte_o(rx_byte), .rx_byte_valid_o(byte_valid),
    .bit_period_o(period), .bit_period_valid_o(per_valid), .bit_rate_err_o(rate_err)
  );
  prog_programmer_model u_prog (
    .clk_i(clk_i), .rst_n_o(rst_n_i), .prog_voltage_o(vpp), .link_clk_o(sclk),
    .serial_data_o(sdin), .primary_rx_o(prx), .secondary_rx_o(srx)
  );

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    tx_serial_bit_i = 1'b0;
    tx_async_bit_i = 1'b0;
    handshake_busy_i = 1'b0;
    cyc = 0;
  end
  // Moving engine levels exercise pin steering
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    tx_async_bit_i <= ~tx_async_bit_i;
    handshake_busy_i <= cyc[2];
    tx_serial_bit_i <= cyc[1];
    if (byte_valid === 1'b1) bytes_q.push_back(rx_byte);
    if (cyc == LIMIT) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Ends mid-cycle, outputs settled
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic enter_mode(input int pulses);
    u_prog.enter(1'b1);
    wait_clk(8);
    `EXPECT_EQ(prog_mode, 1'b1, "no programming mode")
    // Link domain clears only on its own clock
    u_prog.clock_edges(3);
    u_prog.pulse(pulses);
    wait_clk(QUIET + 12);
  endtask
  task automatic t_normal();
    u_prog.enter(1'b0);
    wait_clk(10);
    `EXPECT_EQ({normal_mode, prog_mode}, 2'h2, "ground not normal mode")
    `EXPECT_EQ({cso_oe_n, pto_oe_n, sto_oe_n, hso_oe_n}, 4'hF, "pin driven")
    @(posedge clk_i) ce_i <= 1'b0;
    u_prog.enter(1'b1);
    wait_clk(10);
    `EXPECT_EQ({normal_mode, prog_mode}, 2'h0, "ran with enable low")
    @(posedge clk_i) ce_i <= 1'b1;
  endtask
  task automatic t_select();
    int                     cnt[5] = '{0, 3, 8, 9, 11};
    prog_sel_pkg::channel_t ch[5] = '{prog_sel_pkg::CH_CLOCKED, prog_sel_pkg::CH_CLOCKED_HS,
      prog_sel_pkg::CH_PRIMARY, prog_sel_pkg::CH_SECONDARY, prog_sel_pkg::CH_PRIMARY_HS};
    logic [3:0]             oe[5] = '{4'h7, 4'h6, 4'hB, 4'hD, 4'hA};
    for (int i = 0; i < 5; i++) begin
      enter_mode(cnt[i]);
      `EXPECT_EQ(channel, ch[i], "wrong channel")
      `EXPECT_EQ(sel_err, 1'b0, "select error")
      `EXPECT_EQ({cso_oe_n, pto_oe_n, sto_oe_n, hso_oe_n}, oe[i], "pin steering")
    end
  endtask
  // Counts 1 and 12 leave the link dead
  task automatic t_bad();
    int cnt[2] = '{1, 12};
    int n;
    for (int i = 0; i < 2; i++) begin
      enter_mode(cnt[i]);
      `EXPECT_EQ({sel_err, channel}, {1'b1, prog_sel_pkg::CH_NONE}, "bad count taken")
      n = bytes_q.size();
      u_prog.clock_edges(2);
      u_prog.send_byte(8'h5A);
      wait_clk(20);
      `EXPECT_EQ(bytes_q.size(), n, "traffic taken")
    end
  endtask
  task automatic t_serial();
    int cnt[2] = '{0, 3};
    int n;
    for (int i = 0; i < 2; i++) begin
      enter_mode(cnt[i]);
      n = bytes_q.size();
      u_prog.clock_edges(2);
      u_prog.send_byte(8'hA5);
      u_prog.send_byte(8'h3C);
      for (int k = 0; k < 100 && bytes_q.size() < n + 2; k++) wait_clk(1);
      `EXPECT_EQ(bytes_q.size(), n + 2, "byte count")
      if (bytes_q.size() >= n + 2) `EXPECT_EQ({bytes_q[n], bytes_q[n + 1]}, 16'hA53C, "bytes")
    end
  endtask
  // 400-cycle bit: fine for secondary, too fast for primary
  task automatic t_async();
    int   cnt[2] = '{9, 8};
    logic err[2] = '{1'b0, 1'b1};
    for (int i = 0; i < 2; i++) begin
      enter_mode(cnt[i]);
      u_prog.send_reset_cmd(cnt[i] == 9, 400);
      for (int k = 0; k < 500 && per_valid !== 1'b1; k++) wait_clk(1);
      `EXPECT_EQ({per_valid, period}, {1'b1, 16'h0190}, "bit timing")
      `EXPECT_EQ(rate_err, err[i], "rate flag")
    end
  endtask

  initial begin
    error_cnt = 0;
    n_compared = 0;
    ce_i = 1'b1;
    t_normal();
    t_select();
    t_bad();
    t_serial();
    t_async();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
